// file: src/artmr_pkg.sv
// package of register map, field positions and types for the reload timer
package artmr_pkg;
    // register word indices; the byte address is four times the index
    localparam logic [7:0] ARTMR_IDX_MODE = 8'hE5;
    localparam logic [7:0] ARTMR_IDX_FLAG = 8'hE6;
    localparam logic [7:0] ARTMR_IDX_CFG = 8'hE7;
    localparam logic [7:0] ARTMR_IDX_RELOAD = 8'hE9;
    localparam logic [7:0] ARTMR_IDX_CMP = 8'hEA;
    localparam logic [7:0] ARTMR_IDX_LIVE = 8'hEB;
    localparam int ARTMR_ADDR_W = 10;
    // mode control fields
    localparam int MC_LOAD = 7;
    localparam int MC_EN = 6;
    localparam int MC_OE = 5;
    localparam int MC_EIE = 4;
    localparam int MC_CIE = 3;
    localparam int MC_OIE = 2;
    localparam logic [7:0] MC_RESET = 8'h00;
    // flag fields
    localparam int FL_EDGE = 2;
    localparam int FL_MATCH = 1;
    localparam int FL_WRAP = 0;
    // config fields
    localparam int CF_PS_LO = 5;
    localparam int CF_RSVD = 4;
    localparam int CF_POL = 3;
    localparam int CF_EDGE_ON = 2;
    localparam logic [7:0] CF_RESET = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [1:0] DIV3_LAST = 2'h2;

    typedef enum logic [1:0] {
        ARTMR_AUTO_RELOAD,
        ARTMR_CAPTURE,
        ARTMR_CAPTURE_RESET,
        ARTMR_EDGE_LOAD
    } artmr_mode_t;

    typedef enum logic [1:0] {
        ARTMR_CLK_INT,
        ARTMR_CLK_DIV3,
        ARTMR_CLK_PIN,
        ARTMR_CLK_RSVD
    } artmr_clk_t;

    // interrupt request group
    typedef struct packed {
        logic edge_req;
        logic match_req;
        logic wrap_req;
    } artmr_irq_t;
endpackage

// file: src/artmr_top.sv
// auto-reload timer with capture, compare, pwm and an apb register slave
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module artmr_top
    import artmr_pkg::*;
#(
    parameter int PS_W = 7
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ARTMR_ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // pins
    input wire logic timer_input_pin_i,
    output logic timer_output_pin_o,
    output logic timer_output_pin_oe_n_o,
    // interrupt requests to the core
    output artmr_irq_t irq_o
);
    if (PS_W != 7) begin : g_bad_ps
        $error("prescaler width must be 7");
    end

    logic [7:0] mode_control_reg;
    logic [2:0] flag_status_reg;
    logic [7:0] clock_edge_reg;
    logic [7:0] reload_capture_value;
    logic [7:0] compare_value;
    logic [7:0] timer_counter;
    logic [PS_W-1:0] timer_prescaler;
    logic [1:0] div3_reg;
    logic pwm_reg;
    logic pin_sync_reg;
    logic pin_prev_reg;
    logic [31:0] rdata_reg;

    // apb decode; every access finishes in its first access cycle
    logic wr_en;
    logic rd_en;
    logic [7:0] word_idx;
    logic lane0_wr;
    assign wr_en = psel_i && penable_i && pwrite_i;
    assign rd_en = psel_i && penable_i && !pwrite_i;
    assign word_idx = paddr_i[ARTMR_ADDR_W-1:2];
    assign lane0_wr = wr_en && pstrb_i[0];
    logic hit;
    // decode on the word index; byte lanes above lane 0 are unused
    always_comb begin
        hit = 1'b0;
        unique case (word_idx)
            ARTMR_IDX_MODE, ARTMR_IDX_FLAG, ARTMR_IDX_CFG,
            ARTMR_IDX_RELOAD, ARTMR_IDX_CMP, ARTMR_IDX_LIVE: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end
    // unmapped words answer with an error; writes there do nothing
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !hit;
    assign prdata_o = rdata_reg;

    logic wr_mode;
    logic wr_flag;
    logic wr_cfg;
    logic wr_reload;
    logic wr_cmp;
    logic wr_live;
    // writes act only with byte lane 0 enabled
    assign wr_mode = lane0_wr && word_idx == ARTMR_IDX_MODE;
    assign wr_flag = lane0_wr && word_idx == ARTMR_IDX_FLAG;
    assign wr_cfg = lane0_wr && word_idx == ARTMR_IDX_CFG;
    assign wr_reload = lane0_wr && word_idx == ARTMR_IDX_RELOAD;
    assign wr_cmp = lane0_wr && word_idx == ARTMR_IDX_CMP;
    assign wr_live = lane0_wr && word_idx == ARTMR_IDX_LIVE;

    // pin synchroniser; the edge detector sits behind the second stage
    artmr_sync2 u_artmr_sync2 (
        .clk_i(clk_i),
        .async_i(timer_input_pin_i),
        .sync_o(pin_sync_reg)
    );
    // no reset on the edge history: the stages settle during reset
    always_ff @(posedge clk_i) begin
        pin_prev_reg <= pin_sync_reg;
    end

    artmr_mode_t op_mode;
    artmr_clk_t clk_sel;
    logic count_enable_bit;
    assign count_enable_bit = mode_control_reg[MC_EN];
    assign op_mode = artmr_mode_t'(mode_control_reg[1:0]);
    assign clk_sel = artmr_clk_t'(clock_edge_reg[1:0]);

    logic rise;
    logic fall;
    logic edge_evt;
    assign rise = pin_sync_reg && !pin_prev_reg;
    assign fall = !pin_sync_reg && pin_prev_reg;
    assign edge_evt = clock_edge_reg[CF_EDGE_ON]
        && (clock_edge_reg[CF_POL] ? fall : rise);

    // clock source select; reserved code gives no ticks
    logic src_tick;
    // a pin clock must stay under half of clk_i to be seen
    always_comb begin
        unique case (clk_sel)
            ARTMR_CLK_INT: src_tick = 1'b1;
            ARTMR_CLK_DIV3: src_tick = div3_reg == DIV3_LAST;
            ARTMR_CLK_PIN: src_tick = rise;
            ARTMR_CLK_RSVD: src_tick = 1'b0;
        endcase
    end

    // divide-by-3 runs free, so its phase against a load is open
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            div3_reg <= 2'h0;
        end else if (div3_reg == DIV3_LAST) begin
            div3_reg <= 2'h0;
        end else begin
            div3_reg <= div3_reg + 2'h1;
        end
    end

    // ratio 2**code; tick when low bits of the next count are zero
    logic [PS_W-1:0] ps_inc;
    logic [PS_W-1:0] ps_mask;
    logic [2:0] ps_code;
    logic cnt_tick;
    assign ps_code = clock_edge_reg[CF_PS_LO+2:CF_PS_LO];
    assign ps_inc = timer_prescaler + {{(PS_W-1){1'b0}}, 1'b1};
    // codes above the prescaler width would need a wider prescaler
    assign ps_mask = PS_W'((8'h01 << ps_code) - 8'h01);
    // select only picks the tap, count untouched
    assign cnt_tick = count_enable_bit && src_tick
        && ((ps_inc & ps_mask) == '0);

    // counter events
    logic wrap_evt;
    logic match_evt;
    logic capture_evt;
    logic edge_load_evt;
    logic sw_load;
    assign wrap_evt = cnt_tick && timer_counter == CNT_MAX;
    // capture modes take counter on edge
    assign capture_evt = edge_evt && (op_mode == ARTMR_CAPTURE
        || op_mode == ARTMR_CAPTURE_RESET);
    assign edge_load_evt = edge_evt && op_mode == ARTMR_EDGE_LOAD;
    assign sw_load = wr_mode && pwdata_i[MC_LOAD];
    // capture with reset also restarts the count
    logic cap_clear;
    assign cap_clear = capture_evt && op_mode == ARTMR_CAPTURE_RESET;

    logic [PS_W-1:0] ps_next;
    always_comb begin
        ps_next = timer_prescaler;
        if (sw_load || wr_live || edge_load_evt || cap_clear) begin
            ps_next = '0;
        end else if (count_enable_bit && src_tick) begin
            ps_next = ps_inc;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            timer_prescaler <= '0;
        end else begin
            timer_prescaler <= ps_next;
        end
    end

    // counter next value; cnt_moves marks every cycle it may change
    logic [7:0] cnt_next;
    logic cnt_moves;
    always_comb begin
        cnt_next = timer_counter;
        cnt_moves = 1'b1;
        // live load write goes straight in
        if (wr_live) begin
            cnt_next = pwdata_i[7:0];
        end else if (sw_load || edge_load_evt) begin
            cnt_next = reload_capture_value;
        end else if (cap_clear) begin
            cnt_next = 8'h00;
        end else if (wrap_evt) begin
            cnt_next = reload_capture_value;
        end else if (cnt_tick) begin
            cnt_next = timer_counter + 8'h01;
        end else begin
            cnt_moves = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            timer_counter <= 8'h00;
        end else begin
            timer_counter <= cnt_next;
        end
    end

    // compare match on the value the counter lands on
    // a stopped counter re-sets the flag only when a load or capture clear lands on the compare value
    assign match_evt = cnt_moves && cnt_next == compare_value;

    // no reset on reload and compare data registers; the live counter resets to zero
    // a capture beats a software write to this register in one cycle
    always_ff @(posedge clk_i) begin
        if (capture_evt) begin
            reload_capture_value <= timer_counter;
        end else if (wr_reload) begin
            reload_capture_value <= pwdata_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (wr_cmp) begin
            compare_value <= pwdata_i[7:0];
        end
    end

    // mode control cleared at reset; load bit not stored
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            mode_control_reg <= MC_RESET;
        end else if (wr_mode) begin
            mode_control_reg <= {1'b0, pwdata_i[6:0]};
        end
    end

    // reserved bit stored as written; software keeps it zero
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            clock_edge_reg <= CF_RESET;
        end else if (wr_cfg) begin
            clock_edge_reg <= pwdata_i[7:0];
        end
    end

    // zero clears, one keeps; a new event wins over the clear
    logic [2:0] flag_set;
    assign flag_set = {edge_evt, match_evt, wrap_evt};
    // one flop per flag; the set branch comes first on purpose
    for (genvar i = 0; i < 3; i++) begin : g_flag
        always_ff @(posedge clk_i) begin
            if (!rst_n_i) begin
                flag_status_reg[i] <= 1'b0;
            end else if (flag_set[i]) begin
                flag_status_reg[i] <= 1'b1;
            end else if (wr_flag && !pwdata_i[i]) begin
                flag_status_reg[i] <= 1'b0;
            end
        end
    end

    // overflow sets, match clears, overflow wins a tie
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pwm_reg <= 1'b0;
        end else if (wrap_evt) begin
            pwm_reg <= 1'b1;
        end else if (match_evt) begin
            pwm_reg <= 1'b0;
        end
    end

    // pin released while output disabled
    // released pin is also held low, so it shows no stale level
    assign timer_output_pin_o = pwm_reg && mode_control_reg[MC_OE];
    assign timer_output_pin_oe_n_o = !mode_control_reg[MC_OE];

    // requests are levels; they fall as soon as the flag is cleared
    // edge request
    assign irq_o.edge_req = mode_control_reg[MC_EIE]
        && flag_status_reg[FL_EDGE];
    assign irq_o.match_req = mode_control_reg[MC_CIE]
        && flag_status_reg[FL_MATCH];
    assign irq_o.wrap_req = mode_control_reg[MC_OIE]
        && flag_status_reg[FL_WRAP];

    // read mux; the load bit is never stored
    logic [7:0] rd_byte;
    always_comb begin
        unique case (word_idx)
            ARTMR_IDX_MODE: rd_byte = {1'b0, mode_control_reg[6:0]};
            ARTMR_IDX_FLAG: rd_byte = {5'h00, flag_status_reg};
            ARTMR_IDX_CFG: rd_byte = clock_edge_reg;
            ARTMR_IDX_RELOAD: rd_byte = reload_capture_value;
            ARTMR_IDX_CMP: rd_byte = compare_value;
            ARTMR_IDX_LIVE: rd_byte = timer_counter;
            default: rd_byte = 8'h00;
        endcase
    end

    // read data registered in the setup cycle, ready in access phase
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_reg <= 32'h0000_0000;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            rdata_reg <= {24'h00_0000, rd_byte};
        end
    end

    logic unused_ok;
    assign unused_ok = &{1'b0, rd_en, pwdata_i[31:8], pstrb_i[3:1]};
endmodule // artmr_top

// two-flop synchroniser for a pin from outside the clock domain
module artmr_sync2 (
    // clock
    input wire logic clk_i,
    // pin in, synchronised level out
    input wire logic async_i,
    output logic sync_o
);

    logic meta_reg;
    logic sync_reg;
    // only the second stage leaves this module
    always_ff @(posedge clk_i) begin
        meta_reg <= async_i;
        sync_reg <= meta_reg;
    end
    assign sync_o = sync_reg;
endmodule // artmr_sync2
`default_nettype wire

// file: verification/artmr_chk.sv
// port checker for the reload timer
`timescale 1ns/1ps
`default_nettype none
module artmr_chk
    import artmr_pkg::*;
(
    // clock, reset and bus
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ARTMR_ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    input wire logic [31:0] prdata_o,
    // pins and requests
    input wire logic timer_output_pin_o,
    input wire logic timer_output_pin_oe_n_o,
    input wire artmr_irq_t irq_o
);
    logic wr;
    logic wm;
    logic cw;
    logic cm;
    assign wr = psel_i && penable_i && pwrite_i && pstrb_i[0];
    assign wm = wr && paddr_i[9:2] == ARTMR_IDX_MODE;
    // only a zero write to flag or enable may drop a request
    assign cw = wr && paddr_i[9:2] == ARTMR_IDX_FLAG && !pwdata_i[FL_WRAP]
        || wm && !pwdata_i[MC_OIE];
    assign cm = wr && paddr_i[9:2] == ARTMR_IDX_FLAG && !pwdata_i[FL_MATCH]
        || wm && !pwdata_i[MC_CIE];
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    rst_state_a: assert property ($rose(rst_n_i) |->
        irq_o == 3'h0 && timer_output_pin_oe_n_o) else $error("reset state");
    load_read_a: assert property (psel_i && penable_i && !pwrite_i
        && paddr_i[9:2] == ARTMR_IDX_MODE |-> !prdata_o[MC_LOAD])
        else $error("load bit read as one");
    pin_off_a: assert property (timer_output_pin_oe_n_o |->
        !timer_output_pin_o) else $error("pin driven while off");
    oe_on_a: assert property (wm && pwdata_i[MC_OE] |=>
        !timer_output_pin_oe_n_o) else $error("output not enabled");
    edge_mask_a: assert property (wm && !pwdata_i[MC_EIE] |=>
        !irq_o.edge_req) else $error("edge request not masked");
    match_mask_a: assert property (wm && !pwdata_i[MC_CIE] |=>
        !irq_o.match_req) else $error("match request not masked");
    wrap_mask_a: assert property (wm && !pwdata_i[MC_OIE] |=>
        !irq_o.wrap_req) else $error("wrap request not masked");
    wrap_keep_a: assert property ($fell(irq_o.wrap_req) |->
        $past(cw)) else $error("wrap flag lost");
    match_keep_a: assert property ($fell(irq_o.match_req) |->
        $past(cm)) else $error("match flag lost");
    cover property ($rose(timer_output_pin_o));
    cover property ($rose(irq_o.edge_req));
    cover property ($fell(irq_o.wrap_req));
endmodule // artmr_chk
bind artmr_top artmr_chk u_artmr_chk (.clk_i, .rst_n_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o,
    .timer_output_pin_o, .timer_output_pin_oe_n_o, .irq_o);
`default_nettype wire

// file: verification/artmr_pin_model.sv
// far side: edge source on the timer input, load on the wave pin
`timescale 1ns/1ps
`default_nettype none
module artmr_pin_model (
    // clock and command
    input wire logic clk_i,
    input wire logic flip_i,
    // pins
    input wire logic wave_i,
    input wire logic wave_oe_n_i,
    output logic pin_o,
    output int rises_o
);
    logic wave_q = 1'b0;
    initial pin_o = 1'b0;
    initial rises_o = 0;
    // source is driven, so it holds its level between edges
    always @(posedge clk_i) begin
        if (flip_i) begin
            pin_o <= ~pin_o;
        end
        wave_q <= wave_i;
        if (wave_i && !wave_q && !wave_oe_n_i) begin
            rises_o <= rises_o + 1;
        end
    end
endmodule // artmr_pin_model
`default_nettype wire

// file: verification/auto_reload_timer_regs_test.sv
// self-checking bench for the reload timer
`timescale 1ns/1ps
`default_nettype none
module auto_reload_timer_regs_test import artmr_pkg::*;;
    localparam logic [7:0] AM = ARTMR_IDX_MODE;
    localparam logic [7:0] AF = ARTMR_IDX_FLAG;
    localparam logic [7:0] AC = ARTMR_IDX_CFG;
    localparam logic [7:0] AR = ARTMR_IDX_RELOAD;
    localparam logic [7:0] AL = ARTMR_IDX_LIVE;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [ARTMR_ADDR_W-1:0] paddr_i = '0;
    logic [31:0] pwdata_i = '0;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic se;
    logic pin_i;
    logic pin_o;
    logic oe_n_o;
    logic flip = 1'b0;
    artmr_irq_t irq_o;
    int rises;
    int err_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    logic [7:0] q;
    logic [7:0] q2;
    always #12.5 clk_i = ~clk_i;
    artmr_top u_artmr_top (.clk_i, .rst_n_i, .psel_i, .penable_i,
        .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i(4'h1), .prdata_o,
        .pready_o, .pslverr_o, .timer_input_pin_i(pin_i),
        .timer_output_pin_o(pin_o), .timer_output_pin_oe_n_o(oe_n_o),
        .irq_o);
    artmr_pin_model u_artmr_pin_model (.clk_i, .flip_i(flip),
        .wave_i(pin_o), .wave_oe_n_i(oe_n_o), .pin_o(pin_i),
        .rises_o(rises));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one transfer plus an idle cycle, so drivers never double-assign
    task automatic apb(input bit w, input logic [7:0] a, input logic [7:0] d);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= {a, 2'b00};
        pwdata_i <= {24'h00_0000, d};
        @(posedge clk_i);
        penable_i <= 1'b1;
        @(posedge clk_i);
        while (pready_o !== 1'b1) @(posedge clk_i);
        q = prdata_o[7:0];
        se = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        apb(0, a, 8'h00);
        chk(q, e);
    endtask
    task automatic pulse();
        flip <= 1'b1;
        @(posedge clk_i);
        flip <= 1'b0;
        repeat (5) @(posedge clk_i);
    endtask
    task automatic t_run();
        apb(1, AC, 8'h00);
        apb(1, 8'hEA, 8'hFE);
        apb(1, AR, 8'hFD);
        apb(1, AF, 8'h00);
        apb(1, AM, 8'hFC);
        repeat (12) @(posedge clk_i);
        chk({5'h00, irq_o}, 8'h03);
        chk(8'(rises > 2), 8'h01);
        rc(AM, 8'h7C);
        apb(1, AM, 8'h3C);
        apb(0, AL, 8'h00);
        q2 = q;
        chk(8'(q2 >= 8'hFD), 8'h01);
        rc(AL, q2);
        apb(1, AF, 8'h07);
        rc(AF, 8'h03);
        apb(1, AF, 8'h00);
        rc(AF, 8'h00);
        chk({5'h00, irq_o}, 8'h00);
        apb(1, AM, 8'h00);
        chk({6'h00, oe_n_o, pin_o}, 8'h02);
        $display("test run done");
    endtask
    // eighty enabled edges between the two mode writes
    task automatic t_div();
        for (int c = 0; c < 6; c++) begin
            apb(1, AL, 8'h00);
            apb(1, AC, c < 5 ? 8'(c << 5) : 8'h01);
            apb(1, AM, 8'h40);
            repeat (77) @(posedge clk_i);
            apb(1, AM, 8'h00);
            apb(0, AL, 8'h00);
            // divide-by-3 phase is free, so either count is fine
            if (c == 5) chk(8'(q == 8'd26 || q == 8'd27), 8'h01);
            else chk(q, 8'(80 >> c));
        end
        apb(1, AL, 8'h00);
        apb(1, AC, 8'h02);
        apb(1, AM, 8'h40);
        repeat (6) pulse();
        apb(1, AM, 8'h00);
        rc(AL, 8'h03);
        $display("test div done");
    endtask
    // reserved config bit always written zero
    task automatic t_edge(input logic [7:0] cf, md, lv, fl, el, er);
        apb(1, AC, cf);
        apb(1, AR, 8'h5A);
        apb(1, AL, lv);
        apb(1, AF, 8'h00);
        apb(1, AM, md);
        pulse();
        rc(AF, fl);
        chk({5'h00, irq_o.edge_req, 2'b00}, fl);
        rc(AL, el);
        rc(AR, er);
        $display("test edge %h done", md);
    endtask
    task automatic test_done();
        $display("checked %0d bad %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rc(AM, 8'h00);
        rc(AF, 8'h00);
        rc(AC, 8'h00);
        chk({7'h00, se}, 8'h00);
        rc(8'hE8, 8'h00);
        chk({7'h00, se}, 8'h01);
        t_run();
        t_div();
        t_edge(8'h04, 8'h13, 8'h00, 8'h04, 8'h5A, 8'h5A);
        t_edge(8'h0C, 8'h11, 8'h33, 8'h04, 8'h33, 8'h33);
        t_edge(8'h04, 8'h12, 8'h44, 8'h04, 8'h00, 8'h44);
        t_edge(8'h04, 8'h11, 8'h55, 8'h00, 8'h55, 8'h5A);
        t_edge(8'h08, 8'h11, 8'h66, 8'h00, 8'h66, 8'h5A);
        test_done();
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            test_done();
        end
    end
endmodule // auto_reload_timer_regs_test
`default_nettype wire
